// File: ngp_regs.svh
// Constants for the nibble GPIO port: widths and reset values.
// Assumes it is included by bare name from the package only.
`ifndef NGP_REGS_SVH
`define NGP_REGS_SVH
// Number of port pins, which sit on port bits 3:0.
`define NGP_WIDTH      4
// Direction bits reset to all inputs.
`define NGP_DIR_RST    4'hF
// Individual pull-up enables reset to all enabled.
`define NGP_PU_RST     4'hF
// Change detection resets to off on every pin.
`define NGP_IOC_RST    4'h0
// Global pull-up disable resets to set, so no pull-up is active.
`define NGP_GDIS_RST   1'b1
// All-zero nibble, used for latches and cleared read data.
`define NGP_NIB_ZERO   4'h0
// The port-change flag resets to clear.
`define NGP_FLAG_RST   1'b0
`endif

// File: ngp_pkg.sv
// Types shared by the nibble GPIO port modules.
// Assumes ngp_regs.svh sits in the same folder.
`include "ngp_regs.svh"
package ngp_pkg;
  // One bit per port pin.
  typedef logic [`NGP_WIDTH-1:0] ngp_nib_t;
endpackage

// File: ngp_pin_if.sv
// Interface between the port core and its pin sampler.
// Assumes both ends share the system clock.
interface ngp_pin_if;
  import ngp_pkg::*;
  ngp_nib_t pin_level;  // Synchronised pin levels.
  ngp_nib_t last_read;  // Comparison latch from the last port access.
  ngp_nib_t cmp_en;     // Pins that take part in change detection.
  ngp_nib_t mismatch;   // Per-pin change against the latch.
  modport det (output pin_level, output mismatch,
               input last_read, input cmp_en);
  modport core (input pin_level, input mismatch,
                output last_read, output cmp_en);
endinterface

// File: ngp_pin_sampler.sv
// Pin synchroniser and per-pin change comparator.
// Assumes raw pins are asynchronous to I_CLK_SYS.
module ngp_pin_sampler (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire ngp_pkg::ngp_nib_t i_pin_raw,
  ngp_pin_if.det                pif
);
  import ngp_pkg::*;

  ngp_nib_t sync1_ff;  // First stage, read only by the second stage.
  ngp_nib_t sync2_ff;  // Settled pin levels.

  // Two-stage synchroniser; the first stage feeds nothing else.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_ff <= `NGP_NIB_ZERO;
      sync2_ff <= `NGP_NIB_ZERO;
    end else begin
      sync1_ff <= i_pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  assign pif.pin_level = sync2_ff;

  // Each enabled pin compares its level with the latched value.
  genvar g;
  generate
    for (g = 0; g < `NGP_WIDTH; g++) begin : g_cmp
      assign pif.mismatch[g] = pif.cmp_en[g] &
                               (sync2_ff[g] ^ pif.last_read[g]); // R14
    end
  endgenerate
endmodule // ngp_pin_sampler

// File: ngp_port.sv
// Four-pin bidirectional port with pull-ups and change detection.
// Assumes CPU strobes are one-cycle pulses on I_CLK_SYS and that the
// master-clear and brown-out resets come synchronous to that clock.
// Operation
// R1 - Four pins, each with its direction bit.
// R2 - Direction one tristates the pin driver.
// R3 - Direction zero drives the output latch.
// R4 - Reads give pins; writes go to latch.
// R5 - Writes are read-modify-write of the pins.
// R6 - Direction keeps driver control in analog mode.
// R7 - Analog pins read back as zero.
// R8 - Software clears analog select for digital input.
// R9 - Per-pin weak pull-up enable bits.
// R10 - Output pins never get a pull-up.
// R11 - Pull-ups off after power-on reset.
// R12 - Per-pin change detection enable bits.
// R13 - Change detection off after power-on reset.
// R14 - Mismatches against last read set flag.
// R15 - Port change can wake from Sleep.
// R16 - Software ends mismatch before clearing flag.
// R17 - Persisting mismatch keeps setting the flag.
// R18 - Soft resets keep the comparison latch.
// R19 - Change at the read may be missed.
// R20 - Any access refreshes every latch bit.
// R21 - Hardware sets, software clears; set wins.
// R22 - Global disable gates individual pull-ups.
module ngp_port (
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RESET_N,
  input  wire logic              I_MASTER_CLEAR_RESET_N,
  input  wire logic              I_BROWN_OUT_RESET_N,
  input  wire logic              I_PORT_RD,
  input  wire logic              I_PORT_WR,
  input  wire ngp_pkg::ngp_nib_t I_PORT_WDATA,
  input  wire ngp_pkg::ngp_nib_t I_PORT_WMASK,
  input  wire logic              I_DIR_WR,
  input  wire ngp_pkg::ngp_nib_t I_DIR_WDATA,
  input  wire logic              I_PU_WR,
  input  wire ngp_pkg::ngp_nib_t I_PU_WDATA,
  input  wire logic              I_GDIS_WR,
  input  wire logic              I_GDIS_WDATA,
  input  wire logic              I_IOC_WR,
  input  wire ngp_pkg::ngp_nib_t I_IOC_WDATA,
  input  wire logic              I_FLAG_CLR,
  input  wire ngp_pkg::ngp_nib_t I_ANALOG_SELECT_HIGH,
  input  wire ngp_pkg::ngp_nib_t I_PIN_IN,
  output      ngp_pkg::ngp_nib_t O_PIN_OUT,
  output      ngp_pkg::ngp_nib_t O_PIN_OE_N,
  output      ngp_pkg::ngp_nib_t O_PULL_UP_EN,
  output      ngp_pkg::ngp_nib_t O_PORT_RDATA,
  output      ngp_pkg::ngp_nib_t O_PIN_DIRECTION_BITS,
  output      ngp_pkg::ngp_nib_t O_PULL_UP_ENABLE_BITS,
  output      ngp_pkg::ngp_nib_t O_CHANGE_IRQ_ENABLE_BITS,
  output logic                   O_PULL_UP_GLOBAL_DISABLE,
  output logic                   O_PORT_CHANGE_FLAG,
  output logic                   O_WAKE_REQ
);
  import ngp_pkg::*;

  // Configuration registers.
  ngp_nib_t dir_ff;       // One means input, zero means output.
  ngp_nib_t pu_ff;        // Individual pull-up enables.
  logic     gdis_ff;      // Global pull-up disable.
  ngp_nib_t ioc_ff;       // Change detection enables.
  // Data path registers.
  ngp_nib_t out_ff;       // Output latch.
  ngp_nib_t rdata_ff;     // Value returned by the last port read.
  ngp_nib_t last_rd_ff;   // Comparison latch for change detection.
  logic     flag_ff;      // Shared port-change flag.

  // Next values and decoded terms.
  ngp_nib_t nxt_out;
  ngp_nib_t nxt_rdata;
  ngp_nib_t nxt_last_rd;
  logic     nxt_flag;
  ngp_nib_t digital_rd;   // Pin levels with analog pins forced low.
  logic     port_access;  // Any read or write of the port this cycle.
  logic     soft_rst;     // Master-clear or brown-out reset active.
  logic     any_change;   // OR of all per-pin mismatches.
  logic     flag_set;     // Hardware request to set the flag.

  ngp_pin_if pif ();

  // The sampler synchronises pins and compares them with the latch.
  ngp_pin_sampler u_sampler (
    .i_clk     (I_CLK_SYS),
    .i_reset_n (I_RESET_N),
    .i_pin_raw (I_PIN_IN),
    .pif       (pif)
  );

  // Either soft reset source restores the configuration registers.
  assign soft_rst = !I_MASTER_CLEAR_RESET_N || !I_BROWN_OUT_RESET_N;

  // Analog pins lose their digital input path and read as zero.
  assign digital_rd = pif.pin_level & ~I_ANALOG_SELECT_HIGH; // R7

  assign port_access = I_PORT_RD || I_PORT_WR;

  // Analog pins are also dropped from change detection.
  assign pif.cmp_en = ioc_ff & ~I_ANALOG_SELECT_HIGH; // R12
  assign pif.last_read = last_rd_ff;

  // Mismatches merge into one request.  A change that lands in the
  // access cycle itself is compared against the refreshed latch and
  // can therefore be missed; this is the accepted behaviour.
  assign any_change = |pif.mismatch; // R14
  assign flag_set = any_change && !port_access; // R19

  // A write merges the addressed bits into the sampled pin value,
  // so unaddressed output bits take the pins as a read shows them, analog pins as zero.
  assign nxt_out = I_PORT_WR ?
                   ((digital_rd & ~I_PORT_WMASK) |
                    (I_PORT_WDATA & I_PORT_WMASK)) : out_ff; // R5

  // Reads return the pins, not the output latch.
  assign nxt_rdata = I_PORT_RD ? digital_rd : rdata_ff; // R4

  // Any access refreshes all latch bits together, so a change on a
  // second pin during service of the first is overwritten.
  assign nxt_last_rd = port_access ? pif.pin_level : last_rd_ff; // R20

  // The set has priority over the software clear.
  assign nxt_flag = flag_set ? 1'b1 :
                    (I_FLAG_CLR ? 1'b0 : flag_ff); // R21

  // Configuration registers reset on power-on and on soft resets.
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      dir_ff  <= `NGP_DIR_RST;
      pu_ff   <= `NGP_PU_RST;
      gdis_ff <= `NGP_GDIS_RST; // R11
      ioc_ff  <= `NGP_IOC_RST; // R13
    end else if (soft_rst) begin
      dir_ff  <= `NGP_DIR_RST;
      pu_ff   <= `NGP_PU_RST;
      gdis_ff <= `NGP_GDIS_RST;
      ioc_ff  <= `NGP_IOC_RST;
    end else begin
      // Each register takes its own write strobe.
      if (I_DIR_WR) begin
        dir_ff <= I_DIR_WDATA; // R1
      end
      if (I_PU_WR) begin
        pu_ff <= I_PU_WDATA; // R9
      end
      if (I_GDIS_WR) begin
        gdis_ff <= I_GDIS_WDATA;
      end
      if (I_IOC_WR) begin
        ioc_ff <= I_IOC_WDATA; // R12
      end
    end
  end

  // Output latch and read data survive soft resets unchanged.
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      out_ff   <= `NGP_NIB_ZERO;
      rdata_ff <= `NGP_NIB_ZERO;
    end else begin
      out_ff   <= nxt_out;
      rdata_ff <= nxt_rdata;
    end
  end

  // The comparison latch and flag ignore the soft resets, so a
  // standing mismatch sets the flag again once change detection is re-enabled.
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      last_rd_ff <= `NGP_NIB_ZERO;
      flag_ff    <= `NGP_FLAG_RST;
    end else begin
      last_rd_ff <= nxt_last_rd; // R18
      flag_ff    <= nxt_flag; // R17
    end
  end

  // The driver follows the direction bit alone, analog or not.
  assign O_PIN_OE_N = dir_ff; // R2 R6
  // Tristated pins still show the latch here; OE_N decides the pin.
  assign O_PIN_OUT = out_ff; // R3

  // A pull-up needs its enable, global permission and input mode.
  // Analog pins drop their pull-up as well.
  assign O_PULL_UP_EN = pu_ff & dir_ff & ~I_ANALOG_SELECT_HIGH & // R10
                        {`NGP_WIDTH{!gdis_ff}}; // R22

  assign O_PORT_RDATA             = rdata_ff;
  assign O_PIN_DIRECTION_BITS     = dir_ff;
  assign O_PULL_UP_ENABLE_BITS    = pu_ff;
  assign O_CHANGE_IRQ_ENABLE_BITS = ioc_ff;
  assign O_PULL_UP_GLOBAL_DISABLE = gdis_ff;
  assign O_PORT_CHANGE_FLAG       = flag_ff;
  // The core's sleep controller wakes on the flag.
  assign O_WAKE_REQ = flag_ff; // R15

  // Checks on the port behaviour.

  // A change seen outside an access, then the flag one cycle later.
  sequence s_change_seen;
    any_change && !port_access;
  endsequence

  sequence s_flag_up;
    O_PORT_CHANGE_FLAG && O_WAKE_REQ;
  endsequence

  // A clear strobe with nothing left to set the flag.
  sequence s_clean_clear;
    I_FLAG_CLR && !flag_set;
  endsequence

  a_dir_to_driver: assert property ( // R2
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_DIR_WR && !soft_rst |=> O_PIN_OE_N == $past(I_DIR_WDATA))
    else $error("Driver enables do not follow the direction write.");

  a_write_full_mask: assert property ( // R4
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_PORT_WR && (I_PORT_WMASK == 4'hF)
    |=> O_PIN_OUT == $past(I_PORT_WDATA))
    else $error("Full-mask write did not reach the output latch.");

  a_write_rmw_keep: assert property ( // R5
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_PORT_WR |=> (O_PIN_OUT & ~$past(I_PORT_WMASK)) ==
                  ($past(digital_rd) & ~$past(I_PORT_WMASK)))
    else $error("Unaddressed bits did not take the sampled pins.");

  a_analog_reads_zero: assert property ( // R7
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_PORT_RD |=> (O_PORT_RDATA & $past(I_ANALOG_SELECT_HIGH)) == 4'h0)
    else $error("An analog pin read back as one.");

  a_no_pull_on_out: assert property ( // R10
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (O_PULL_UP_EN & ~O_PIN_OE_N) == 4'h0)
    else $error("Pull-up active on an output pin.");

  a_global_pull_off: assert property ( // R22
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_GDIS_WR && I_GDIS_WDATA |=> O_PULL_UP_EN == 4'h0 [*2])
    else $error("Pull-up active under global disable.");

  a_flag_sets: assert property ( // R17
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    s_change_seen |=> s_flag_up)
    else $error("Mismatch did not set the change flag.");

  a_flag_clears: assert property ( // R21
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    s_clean_clear |=> !O_PORT_CHANGE_FLAG)
    else $error("Flag clear did not take effect.");

  a_flag_sticky: assert property ( // R21
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    O_PORT_CHANGE_FLAG && !I_FLAG_CLR |=> O_PORT_CHANGE_FLAG)
    else $error("Change flag dropped without a clear.");

  a_latch_refresh: assert property ( // R20
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    port_access |=> last_rd_ff == $past(pif.pin_level))
    else $error("Port access did not refresh the latch.");

  a_latch_soft_keep: assert property ( // R18
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    soft_rst && !port_access |=> $stable(last_rd_ff))
    else $error("Soft reset disturbed the comparison latch.");

  a_ioc_off_soft: assert property ( // R13
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    soft_rst |=> O_CHANGE_IRQ_ENABLE_BITS == 4'h0 &&
                 O_PULL_UP_GLOBAL_DISABLE)
    else $error("Soft reset left detection or pull-ups enabled.");

  // A pull-up never appears on a pin whose own enable bit is clear.
  a_pull_needs_bit: assert property ( // R9
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (O_PULL_UP_EN & ~O_PULL_UP_ENABLE_BITS) == `NGP_NIB_ZERO)
    else $error("Pull-up active without its enable bit.");

  // The global disable overrides every individual enable at once.
  a_gdis_gates_pull: assert property ( // R22
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    O_PULL_UP_GLOBAL_DISABLE |-> O_PULL_UP_EN == `NGP_NIB_ZERO)
    else $error("Pull-up active while globally disabled.");

  // A read returns the settled pins with analog pins masked off.
  a_read_gives_pins: assert property ( // R4
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_PORT_RD |=> O_PORT_RDATA ==
                  ($past(pif.pin_level) & ~$past(I_ANALOG_SELECT_HIGH)))
    else $error("Read data is not the sampled pin levels.");

  // Read data holds between reads, soft resets included.
  a_rdata_holds: assert property ( // R4
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    !I_PORT_RD |=> $stable(O_PORT_RDATA))
    else $error("Read data changed without a read.");

  // The output latch only moves on a port write.
  a_out_holds: assert property ( // R3
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    !I_PORT_WR |=> $stable(O_PIN_OUT))
    else $error("Output latch changed without a write.");

  // Soft resets return the pins to inputs with no pull-ups.
  a_cfg_soft_reset: assert property ( // R11
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    soft_rst |=> O_PIN_DIRECTION_BITS == `NGP_DIR_RST &&
                 O_PULL_UP_EN == `NGP_NIB_ZERO)
    else $error("Soft reset left outputs or pull-ups active.");

  // An access cycle never raises a clear flag by itself.
  a_access_no_set: assert property ( // R19
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    port_access && !O_PORT_CHANGE_FLAG |=> !O_PORT_CHANGE_FLAG)
    else $error("Change flag rose out of an access cycle.");

  // Without a mismatch a clear flag stays clear.
  a_no_spurious_set: assert property ( // R14
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    !O_PORT_CHANGE_FLAG && !any_change |=> !O_PORT_CHANGE_FLAG)
    else $error("Change flag rose without a mismatch.");

  // Only enabled pins may report a mismatch.
  a_mismatch_enabled: assert property ( // R12
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (pif.mismatch & ~ioc_ff) == `NGP_NIB_ZERO)
    else $error("Mismatch reported on a disabled pin.");

  // Analog pins take no part in change detection.
  a_analog_no_detect: assert property ( // R12
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (pif.mismatch & I_ANALOG_SELECT_HIGH) == `NGP_NIB_ZERO)
    else $error("Mismatch reported on an analog pin.");

  // A set request in the clear cycle keeps the flag up.
  a_flag_set_wins: assert property ( // R21
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    flag_set && I_FLAG_CLR |=> O_PORT_CHANGE_FLAG)
    else $error("Clear beat a standing mismatch.");
endmodule // ngp_port

// File: ngp_pin_model.sv
// Behavioural model of the circuitry outside the four port pins.
// Assumes the bench drives ext_val and ext_en off the sampling edge.
module ngp_pin_model
  import ngp_pkg::*;
(
  input  wire logic     i_clk,
  input  wire ngp_nib_t i_oe_n,
  input  wire ngp_nib_t i_pin_out,
  input  wire ngp_nib_t i_pull_en,
  input  wire ngp_nib_t i_ext_val,
  input  wire ngp_nib_t i_ext_en,
  output      ngp_nib_t o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  ngp_nib_t float_ff = '0; // Pattern seen on a pin that nobody holds.

  // A floating pin toggles every cycle, so a stale value never passes.
  always @(posedge i_clk) begin
    float_ff <= ~float_ff;
  end

  // Device driver wins, then the outside driver, then the weak pull-up.
  assign o_pin = (~i_oe_n & i_pin_out)
               | (i_oe_n & i_ext_en & i_ext_val)
               | (i_oe_n & ~i_ext_en & i_pull_en)
               | (i_oe_n & ~i_ext_en & ~i_pull_en & float_ff);
endmodule // ngp_pin_model

// File: ngp_port_tb.sv
// Self-checking bench for the nibble port, driving CPU strobes as pulses.
// Assumes ngp_pin_model resolves the pin levels seen by the port.
module ngp_port_tb;
  import ngp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic     clk = 1'b0, rst_n = 1'b0, master_clear_reset_n = 1'b1, bor_n = 1'b1;
  logic     port_rd = 1'b0, port_wr = 1'b0, dir_wr = 1'b0, pu_wr = 1'b0;
  logic     gdis_wr = 1'b0, gdis_d = 1'b0, ioc_wr = 1'b0, flag_clr = 1'b0;
  ngp_nib_t wdata = '0, wmask = '0, cfg_d = '0, analog = '0;
  ngp_nib_t ext_val = '0, ext_en = '0, pins;
  ngp_nib_t pin_out, oe_n, pull_en, rdata, dir_rb, pu_rb, ioc_rb;
  logic     gdis_rb, flag, wake;
  int       miscompares = 0, n_compared = 0;

  // Clock at 100 MHz.
  initial begin
    forever #5 clk = ~clk;
  end

  ngp_port i_dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n),
    .I_MASTER_CLEAR_RESET_N(master_clear_reset_n), .I_BROWN_OUT_RESET_N(bor_n),
    .I_PORT_RD(port_rd), .I_PORT_WR(port_wr), .I_PORT_WDATA(wdata),
    .I_PORT_WMASK(wmask), .I_DIR_WR(dir_wr), .I_DIR_WDATA(cfg_d),
    .I_PU_WR(pu_wr), .I_PU_WDATA(cfg_d), .I_GDIS_WR(gdis_wr),
    .I_GDIS_WDATA(gdis_d), .I_IOC_WR(ioc_wr), .I_IOC_WDATA(cfg_d),
    .I_FLAG_CLR(flag_clr), .I_ANALOG_SELECT_HIGH(analog), .I_PIN_IN(pins),
    .O_PIN_OUT(pin_out), .O_PIN_OE_N(oe_n), .O_PULL_UP_EN(pull_en),
    .O_PORT_RDATA(rdata), .O_PIN_DIRECTION_BITS(dir_rb),
    .O_PULL_UP_ENABLE_BITS(pu_rb), .O_CHANGE_IRQ_ENABLE_BITS(ioc_rb),
    .O_PULL_UP_GLOBAL_DISABLE(gdis_rb), .O_PORT_CHANGE_FLAG(flag),
    .O_WAKE_REQ(wake));

  ngp_pin_model i_pins (.i_clk(clk), .i_oe_n(oe_n), .i_pin_out(pin_out),
    .i_pull_en(pull_en), .i_ext_val(ext_val), .i_ext_en(ext_en),
    .o_pin(pins));

  // One strobe: 0 port write, 1 dir, 2 pull-up, 3 global, 4 change
  // enable, 5 port read, 6 flag clear. Returns once the answer stands.
  task automatic strobe(input int k, input ngp_nib_t d, input ngp_nib_t m);
    @(posedge clk);
    case (k)
      0: begin port_wr <= 1'b1; wdata <= d; wmask <= m; end
      1: begin dir_wr <= 1'b1; cfg_d <= d; end
      2: begin pu_wr <= 1'b1; cfg_d <= d; end
      3: begin gdis_wr <= 1'b1; gdis_d <= d[0]; end
      4: begin ioc_wr <= 1'b1; cfg_d <= d; end
      5: port_rd <= 1'b1;
      default: flag_clr <= 1'b1;
    endcase
    @(posedge clk);
    {port_wr, dir_wr, pu_wr, gdis_wr, ioc_wr, port_rd, flag_clr} <= '0;
    #1;
  endtask

  // Lets a pin change cross the synchroniser and reach the flag.
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input ngp_nib_t got, input ngp_nib_t exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short; the sequence needs well under 2000 cycles.
  initial begin
    #20us;
    miscompares++;
    final_report();
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(dir_rb, 4'hF, "dir reset");
    chk(oe_n, 4'hF, "oe reset");
    chk(gdis_rb, 1'b1, "global disable reset");
    chk(pull_en, 4'h0, "pull-ups at reset");
    chk(ioc_rb, 4'h0, "change enable reset");
    chk(flag, 1'b0, "flag reset");
    $display("test reset values done");
    // Write merges sampled pins with masked data; driver stays off.
    ext_en <= 4'hF;
    ext_val <= 4'h5;
    settle();
    strobe(0, 4'h2, 4'h3);
    chk(pin_out, 4'h6, "merged latch");
    chk(oe_n, 4'hF, "inputs stay off");
    strobe(5, '0, '0);
    chk(rdata, 4'h5, "read gives pins");
    ext_en <= 4'h0;
    strobe(1, 4'hC, '0);
    chk(oe_n, 4'hC, "per-pin direction");
    strobe(1, 4'h0, '0);
    settle();
    strobe(5, '0, '0);
    chk(rdata, 4'h6, "latch driven out");
    strobe(0, 4'hA, 4'hF);
    chk(pin_out, 4'hA, "full-mask write");
    settle();
    $display("test direction and merge done");
    // Analog pins read zero but keep their driver.
    analog <= 4'h3;
    strobe(5, '0, '0);
    chk(oe_n, 4'h0, "driver in analog");
    chk(rdata, 4'h8, "analog reads zero");
    analog <= 4'h0;
    strobe(5, '0, '0);
    chk(rdata, 4'hA, "digital again");
    $display("test analog done");
    // Pull-ups: global gate, per-pin bits, outputs never pulled.
    strobe(1, 4'hF, '0);
    strobe(3, 4'h0, '0);
    strobe(2, 4'h5, '0);
    chk(pull_en, 4'h5, "per-pin pull-up");
    chk(pu_rb, 4'h5, "pull-up bits readback");
    strobe(1, 4'hC, '0);
    chk(pull_en, 4'h4, "output loses pull");
    strobe(3, 4'h1, '0);
    chk(pull_en, 4'h0, "global disable");
    strobe(3, 4'h0, '0);
    strobe(2, 4'hF, '0);
    strobe(1, 4'hF, '0);
    $display("test pull-ups done");
    // Change detection on pin 1 only; pins idle high by pull-up.
    strobe(4, 4'h2, '0);
    chk(ioc_rb, 4'h2, "change enable");
    settle();
    strobe(5, '0, '0);
    ext_en <= 4'hF;
    ext_val <= 4'hE;
    settle();
    chk(flag, 1'b0, "disabled pin ignored");
    ext_val <= 4'hC;
    settle();
    chk(flag, 1'b1, "mismatch sets flag");
    chk(wake, 1'b1, "wake request");
    strobe(6, '0, '0);
    chk(flag, 1'b1, "clear refused");
    strobe(5, '0, '0);
    chk(rdata, 4'hC, "read ends mismatch");
    strobe(6, '0, '0);
    chk(flag, 1'b0, "clear after read");
    // Two pins change; one read ends both mismatches at once.
    strobe(4, 4'h3, '0);
    ext_val <= 4'hD;
    settle();
    ext_val <= 4'hF;
    settle();
    strobe(5, '0, '0);
    strobe(6, '0, '0);
    chk(flag, 1'b0, "read refreshes all");
    $display("test change detection done");
    // Soft resets keep the comparison latch, so the flag stands.
    for (int k = 0; k < 2; k++) begin
      ext_val <= 4'hF;
      settle();
      strobe(5, '0, '0);
      ext_val <= 4'hC;
      settle();
      if (k == 0) master_clear_reset_n <= 1'b0;
      else bor_n <= 1'b0;
      repeat (3) @(posedge clk);
      {master_clear_reset_n, bor_n} <= 2'b11;
      #1;
      chk(dir_rb, 4'hF, "config after soft reset");
      strobe(4, 4'h3, '0);
      strobe(6, '0, '0);
      chk(flag, 1'b1, "latch kept over reset");
      strobe(5, '0, '0);
      strobe(6, '0, '0);
      chk(flag, 1'b0, "cleared after read");
    end
    $display("test soft resets done");
    final_report();
  end
endmodule // ngp_port_tb
